// ===== nand_host_pkg.sv
// Purpose: constants shared by the cache-program / copy / erase host sequencer
// Assumes: byte-wide flash port, one 100 MHz clock
// Notes: command codes, pin timing counts, status bit positions, register map
// Summary of operation
// - restart dual cache program when block advances
// - full block: 64 pages then final program
// - dual program ends with second input, final
// - pair blocks within same half only
// - at most one block per district
// - page-in-block bits equal for both blocks
// - input, address, dummy, input, address, program
// - only sequence, status and reset commands
// - copy cache command programs while reading next
// - copy: give address, change only needed bytes
// - single copy stays inside one district
// - copy ends with copy-program then final
// - keep write protect high during copy
// - dual copy restarts when block advances
// - dual erase: two setup groups then confirm
package nand_host_pkg;
   // flash command codes
   localparam logic [7:0] CMD_DATA_IN = 8'h80;
   localparam logic [7:0] CMD_DATA_IN2 = 8'h81;
   localparam logic [7:0] CMD_DUMMY_PROG = 8'h11;
   localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
   localparam logic [7:0] CMD_FINAL_PROG = 8'h10;
   localparam logic [7:0] CMD_COPY_PROG = 8'h8c;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_STATUS_EXT = 8'h71;
   localparam logic [7:0] CMD_RESET = 8'hff;
   // software order codes
   localparam logic [2:0] OP_PROG_CACHE = 3'h0;
   localparam logic [2:0] OP_PROG_FINAL = 3'h1;
   localparam logic [2:0] OP_COPY_CACHE = 3'h2;
   localparam logic [2:0] OP_COPY_FINAL = 3'h3;
   localparam logic [2:0] OP_ERASE = 3'h4;
   localparam logic [2:0] OP_RESET = 3'h5;
   // register addresses of the host's own port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ROW_A = 4'h1;
   localparam logic [3:0] REG_ROW_B = 4'h2;
   localparam logic [3:0] REG_COL = 4'h3;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_FLASH_ST = 4'h6;
   // control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_DUAL_BIT = 3;
   localparam int CTRL_GO_BIT = 4;
   localparam int CTRL_DATA_LSB = 8;
   // extended status bit positions (bit 0 is the first I/O line)
   localparam int ST_FAIL = 0;
   localparam int ST_D0_CUR = 1;
   localparam int ST_D1_CUR = 2;
   localparam int ST_D0_PREV = 3;
   localparam int ST_D1_PREV = 4;
   localparam int ST_READY = 5;
   localparam int ST_CACHE_READY = 6;
   // address layout
   localparam int PAGE_BITS = 6;
   localparam int ROW_W = 18;
   localparam int BLK_MSB = ROW_W - 1;
   localparam int PAGES_PER_BLOCK = 64;
   // strobe timing
   localparam int CLK_NS = 10;
   localparam int STROBE_NS = 20;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAIT_NS = 100;
   localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== strobe_timer.sv
// Purpose: counts down one strobe phase of the flash port
// Assumes: load has priority over counting
// Notes: done is a level while the count is zero
`timescale 1ns/10ps
module strobe_timer #(
   parameter int W = 8
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic load_in,
   input wire logic [W-1:0] value_in,
   output logic done_out
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   // reload or count toward zero
   always_comb begin
      nxt_cnt = cnt_ff;
      if (load_in) begin
         nxt_cnt = value_in;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - W'(1);
      end
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   assign done_out = (cnt_ff == '0);
endmodule // strobe_timer

// ===== nand_host.sv
// Purpose: host sequencer driving program, copy and erase orders onto a flash
// Assumes: software writes page data to REG_DATA while data_req is set
// Notes: reads extended status after each order until the device is ready
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module nand_host
   import nand_host_pkg::*;
#(
   parameter int MAX_POLLS = 1000000
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic [7:0] io_out,
   output logic io_oe_out,
   input wire logic [7:0] io_in,
   output logic cmd_latch_out,
   output logic addr_latch_out,
   output logic chip_en_n_out,
   output logic write_strobe_n_out,
   output logic read_strobe_n_out,
   output logic write_protect_n_out
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_CMD1 = 4'h1,
      S_ADDR1 = 4'h2,
      S_DATA1 = 4'h3,
      S_MID = 4'h4,
      S_CMD2 = 4'h5,
      S_ADDR2 = 4'h6,
      S_DATA2 = 4'h7,
      S_LAST = 4'h8,
      S_POLL_CMD = 4'h9,
      S_POLL_RD = 4'ha,
      S_DONE = 4'hb
   } phase_e;

   typedef struct packed {
      phase_e phase;
      logic [2:0] step; // byte index inside an address group, up to five bytes
      logic [2:0] op;
      logic dual;
      logic second; // second group of a dual order in progress
      logic [ROW_W-1:0] row_a;
      logic [ROW_W-1:0] row_b;
      logic [15:0] col;
      logic [7:0] data;
      logic data_req;
      logic data_valid;
      logic data_last;
      logic busy;
      logic error;
      logic timeout;
      logic [7:0] flash_st;
      logic [31:0] polls;
      logic [31:0] rdata;
      logic [7:0] io;
      logic io_oe;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic wp_n;
      logic ce_n; // chip enable kept in its own flop, low while an order runs
      logic load;
   } state_s;

   state_s st_ff;
   state_s nxt_st;
   logic strobe_done;

   // one timer paces every strobe phase on the port
   strobe_timer #(.W(8)) u_timer (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .load_in(st_ff.load),
      .value_in(8'(STROBE_CYC)),
      .done_out(strobe_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address byte of the current group: two column bytes then three row bytes, or three row bytes only for erase
   function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [15:0] col,
                                            input logic [ROW_W-1:0] row, input logic row_only);
      logic [23:0] r;
      r = {{(24 - ROW_W){1'b0}}, row};
      if (row_only) begin
         addr_byte = r[8*idx[1:0] +: 8];
      end else if (idx < 3'h2) begin
         addr_byte = col[8*idx[0] +: 8];
      end else begin
         addr_byte = r[8*(idx - 3'h2) +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic: one port byte per strobe phase
   always_comb begin
      logic erase;
      logic [2:0] nbytes;
      logic [2:0] idx;
      logic issue;
      logic pair_ok;
      erase = (st_ff.op == OP_ERASE);
      nbytes = erase ? 3'h3 : 3'h5;
      idx = st_ff.step;
      issue = 1'b0;
      // pair rule: same half, one block per district, same page (erase skips page)
      pair_ok = (st_ff.row_a[BLK_MSB] == st_ff.row_b[BLK_MSB])
                && (st_ff.row_a[PAGE_BITS] != st_ff.row_b[PAGE_BITS])
                && (wdata_in[CTRL_OP_LSB +: 3] == OP_ERASE
                    || st_ff.row_a[PAGE_BITS-1:0] == st_ff.row_b[PAGE_BITS-1:0]);
      nxt_st = st_ff;
      nxt_st.load = 1'b0;
      nxt_st.rdata = 32'h0;
      // register reads answer in the next cycle
      if (rd_in) begin
         unique case (addr_in)
            REG_CTRL: nxt_st.rdata = {28'h0, st_ff.dual, st_ff.op};
            REG_ROW_A: nxt_st.rdata = 32'(st_ff.row_a);
            REG_ROW_B: nxt_st.rdata = 32'(st_ff.row_b);
            REG_COL: nxt_st.rdata = {16'h0, st_ff.col};
            REG_STATUS: nxt_st.rdata = {27'h0, st_ff.timeout, st_ff.error,
                                        st_ff.data_req, 1'b0, st_ff.busy};
            REG_FLASH_ST: nxt_st.rdata = {24'h0, st_ff.flash_st};
            default: nxt_st.rdata = 32'h0;
         endcase
      end
      // register writes; addresses and orders only taken while idle
      if (wr_in && !st_ff.busy) begin
         unique case (addr_in)
            REG_ROW_A: nxt_st.row_a = wdata_in[ROW_W-1:0];
            REG_ROW_B: nxt_st.row_b = wdata_in[ROW_W-1:0];
            REG_COL: nxt_st.col = wdata_in[15:0];
            REG_CTRL: begin
               // a dual order whose blocks cannot pair is refused before the port moves
               if (wdata_in[CTRL_GO_BIT] && wdata_in[CTRL_DUAL_BIT] && !pair_ok) begin
                  nxt_st.error = 1'b1;
               end else if (wdata_in[CTRL_GO_BIT]) begin
                  // every order restarts the whole sequence from its first command
                  nxt_st.op = wdata_in[CTRL_OP_LSB +: 3];
                  nxt_st.dual = wdata_in[CTRL_DUAL_BIT];
                  nxt_st.busy = 1'b1;
                  nxt_st.error = 1'b0;
                  nxt_st.timeout = 1'b0;
                  nxt_st.second = 1'b0;
                  nxt_st.step = 3'h0;
                  nxt_st.phase = S_CMD1;
               end
            end
            default: ;
         endcase
      end
      // a data byte is accepted while the sequencer asks for one
      if (wr_in && addr_in == REG_DATA && st_ff.data_req && !st_ff.data_valid) begin
         nxt_st.data = wdata_in[7:0];
         nxt_st.data_last = wdata_in[CTRL_DATA_LSB];
         nxt_st.data_valid = 1'b1;
      end
      // strobe engine: low phase then high phase, one timer load each
      if (!st_ff.we_n && strobe_done && !st_ff.load) begin
         nxt_st.we_n = 1'b1; // device latches on this rising edge
         nxt_st.load = 1'b1;
      end else if (!st_ff.re_n && strobe_done && !st_ff.load) begin
         nxt_st.re_n = 1'b1;
         nxt_st.flash_st = io_in;
         nxt_st.load = 1'b1;
         nxt_st.phase = io_in[ST_READY] ? S_DONE : S_POLL_CMD;
         nxt_st.polls = st_ff.polls + 32'h1;
         if (st_ff.polls >= 32'(MAX_POLLS)) begin
            nxt_st.timeout = 1'b1;
            nxt_st.phase = S_DONE;
         end
      end else if (st_ff.we_n && st_ff.re_n && strobe_done && !st_ff.load) begin
         issue = 1'b1;
      end
      if (issue) begin
         nxt_st.cle = 1'b0;
         nxt_st.ale = 1'b0;
         nxt_st.io_oe = 1'b1;
         unique case (st_ff.phase)
            S_IDLE: begin
               // protect is left as the last order set it, so a cache chain keeps it off
               nxt_st.io_oe = 1'b0;
            end
            S_CMD1: begin
               nxt_st.wp_n = 1'b1;
               nxt_st.cle = 1'b1;
               nxt_st.we_n = 1'b0;
               nxt_st.load = 1'b1;
               nxt_st.step = 3'h0;
               unique case (st_ff.op)
                  OP_ERASE: nxt_st.io = CMD_ERASE_SETUP;
                  OP_RESET: nxt_st.io = CMD_RESET;
                  OP_COPY_CACHE, OP_COPY_FINAL: nxt_st.io = CMD_COPY_PROG;
                  default: nxt_st.io = st_ff.second ? CMD_DATA_IN2 : CMD_DATA_IN;
               endcase
               nxt_st.phase = (st_ff.op == OP_RESET) ? S_POLL_CMD : S_ADDR1;
            end
            S_ADDR1: begin
               nxt_st.ale = 1'b1;
               nxt_st.we_n = 1'b0;
               nxt_st.load = 1'b1;
               nxt_st.io = addr_byte(idx, st_ff.col,
                                     st_ff.second ? st_ff.row_b : st_ff.row_a, erase);
               // step must reach the fifth byte, a two-bit count would wrap forever
               nxt_st.step = st_ff.step + 3'h1;
               if (idx == nbytes - 3'h1) begin
                  nxt_st.step = 3'h0;
                  nxt_st.phase = erase ? S_MID : S_DATA1;
                  nxt_st.data_req = !erase; // copy waits for data too; a byte with the last flag ends it
               end
            end
            S_DATA1: begin
               if (st_ff.data_valid) begin
                  nxt_st.we_n = 1'b0;
                  nxt_st.load = 1'b1;
                  nxt_st.io = st_ff.data;
                  nxt_st.data_valid = 1'b0;
                  if (st_ff.data_last) begin
                     nxt_st.data_req = 1'b0;
                     nxt_st.phase = S_MID;
                  end
               end else begin
                  nxt_st.io_oe = 1'b0; // stall: data not yet supplied
               end
            end
            S_MID: begin
               if (st_ff.dual && !st_ff.second) begin
                  // dual order: dummy program, or for erase the next setup group
                  nxt_st.second = 1'b1;
                  nxt_st.phase = S_CMD1;
                  if (!erase) begin
                     nxt_st.cle = 1'b1;
                     nxt_st.we_n = 1'b0;
                     nxt_st.load = 1'b1;
                     nxt_st.io = CMD_DUMMY_PROG;
                  end
               end else begin
                  nxt_st.phase = S_LAST;
                  nxt_st.io_oe = 1'b0;
               end
            end
            S_LAST: begin
               nxt_st.cle = 1'b1;
               nxt_st.we_n = 1'b0;
               nxt_st.load = 1'b1;
               nxt_st.polls = 32'h0;
               nxt_st.phase = S_POLL_CMD;
               unique case (st_ff.op)
                  OP_ERASE: nxt_st.io = CMD_ERASE_GO;
                  OP_PROG_CACHE, OP_COPY_CACHE: nxt_st.io = CMD_CACHE_PROG;
                  default: nxt_st.io = CMD_FINAL_PROG;
               endcase
            end
            S_POLL_CMD: begin
               nxt_st.cle = 1'b1;
               nxt_st.we_n = 1'b0;
               nxt_st.load = 1'b1;
               nxt_st.io = CMD_STATUS_EXT;
               nxt_st.phase = S_POLL_RD;
            end
            S_POLL_RD: begin
               nxt_st.io_oe = 1'b0;
               nxt_st.re_n = 1'b0;
               nxt_st.load = 1'b1;
            end
            S_DONE: begin
               nxt_st.io_oe = 1'b0;
               nxt_st.busy = 1'b0;
               nxt_st.phase = S_IDLE;
               // error is OR of the fail bit, the district current-page results and timeout
               nxt_st.error = st_ff.flash_st[ST_FAIL] | st_ff.flash_st[ST_D0_CUR]
                              | st_ff.flash_st[ST_D1_CUR] | st_ff.timeout;
               // a cache order leaves write protect off for the next page
               if (st_ff.op == OP_ERASE || st_ff.op == OP_RESET
                   || st_ff.op == OP_PROG_FINAL || st_ff.op == OP_COPY_FINAL) begin
                  nxt_st.wp_n = 1'b0;
               end
            end
            default: nxt_st.phase = S_IDLE;
         endcase
      end
      // chip enable follows busy from its own flop
      nxt_st.ce_n = !nxt_st.busy;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset idles the port with strobes high and write protect asserted
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_ff <= '{phase: S_IDLE, we_n: 1'b1, re_n: 1'b1, ce_n: 1'b1, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs all straight from the state register
   assign rdata_out = st_ff.rdata;
   assign io_out = st_ff.io;
   assign io_oe_out = st_ff.io_oe;
   assign cmd_latch_out = st_ff.cle;
   assign addr_latch_out = st_ff.ale;
   assign chip_en_n_out = st_ff.ce_n;
   assign write_strobe_n_out = st_ff.we_n;
   assign read_strobe_n_out = st_ff.re_n;
   assign write_protect_n_out = st_ff.wp_n;
endmodule // nand_host

// ===== nand_host_props.sv
// Purpose: port checks on the flash host sequencer
// Assumes: bound to nand_host, one clock domain
// Notes: a strobe stays low for STROBE_CYC plus two cycles, load and count
`timescale 1ns/10ps
module nand_host_props (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic [7:0] io_out,
   input wire logic io_oe_out,
   input wire logic cmd_latch_out,
   input wire logic addr_latch_out,
   input wire logic chip_en_n_out,
   input wire logic write_strobe_n_out,
   input wire logic read_strobe_n_out,
   input wire logic write_protect_n_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////////////
   // port relations; a latched byte must be steady for the device to take it
   strobe_excl_a: assert property (!(!write_strobe_n_out && !read_strobe_n_out))
      else $error("both strobes low");
   latch_excl_a: assert property (!(cmd_latch_out && addr_latch_out))
      else $error("command and address latch together");
   write_drive_a: assert property (!write_strobe_n_out |-> io_oe_out && !chip_en_n_out)
      else $error("write strobe without driven bus");
   read_release_a: assert property (!read_strobe_n_out |-> !io_oe_out)
      else $error("bus driven during status read");
   write_width_a: assert property ($fell(write_strobe_n_out) |=>
      !write_strobe_n_out [*3] ##1 write_strobe_n_out)
      else $error("write strobe width wrong");
   read_width_a: assert property ($fell(read_strobe_n_out) |=>
      !read_strobe_n_out [*3] ##1 read_strobe_n_out)
      else $error("read strobe width wrong");
   protect_off_a: assert property (!write_strobe_n_out |-> write_protect_n_out)
      else $error("write protect active during order");
   byte_steady_a: assert property (!write_strobe_n_out && !$past(write_strobe_n_out)
      |-> $stable(io_out) && $stable(cmd_latch_out))
      else $error("byte changed under write strobe");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside read slot");
endmodule // nand_host_props

bind nand_host nand_host_props chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .io_out(io_out), .io_oe_out(io_oe_out),
   .cmd_latch_out(cmd_latch_out), .addr_latch_out(addr_latch_out),
   .chip_en_n_out(chip_en_n_out), .write_strobe_n_out(write_strobe_n_out),
   .read_strobe_n_out(read_strobe_n_out), .write_protect_n_out(write_protect_n_out));

// ===== flash_model.sv
// Purpose: behavioural flash device answering extended status
// Assumes: bytes taken on rising write strobe while selected
// Notes: busy for three status reads after each program or erase
`timescale 1ns/10ps
module flash_model (
   input wire logic [7:0] byte_in,
   input wire logic cle_in,
   input wire logic ale_in,
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic re_n_in,
   input wire logic wp_n_in,
   input wire logic fail_d1_in,
   output logic [7:0] resp_out
);
   logic [7:0] cmd_log [$];
   int addr_count = 0;
   int polls_left = 0;
   logic [1:0] cur = 2'h0;
   logic [1:0] prev = 2'h0;
   logic [7:0] last = 8'h0;
   logic [7:0] st;
   ////////////////////////////////////////////////////////////////////////////////
   // ready bits, per-district results and their or
   assign st = {wp_n_in, polls_left == 0, polls_left == 0, prev, cur, |cur};
   // released bus shows the inverse so a stale byte never passes
   assign resp_out = !re_n_in ? st : ~last;
   // commands and address bytes; program pulse and verify counted as busy polls
   always @(posedge we_n_in) begin
      if (!ce_n_in && cle_in) begin
         cmd_log.push_back(byte_in);
         if (byte_in == 8'h10 || byte_in == 8'h15 || byte_in == 8'hd0) begin
            prev = cur;
            cur = {fail_d1_in, 1'b0};
            polls_left = 3;
         end
      end
      if (!ce_n_in && ale_in) begin
         addr_count++;
      end
   end
   // each completed status read brings ready closer
   always @(posedge re_n_in) begin
      last = st;
      if (polls_left > 0) begin
         polls_left--;
      end
   end
endmodule // flash_model

// ===== nand_cache_program_copy_erase_test.sv
// Purpose: self-checking bench for the flash host sequencer
// Assumes: flash_model on the byte port, checker bound
// Notes: MAX_POLLS shortened to 20
`timescale 1ns/10ps
module nand_cache_program_copy_erase_test;
   import nand_host_pkg::*;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic fail_d1 = 1'b0;
   logic [31:0] rdata_out;
   logic [7:0] io_out, io_in;
   logic io_oe_out, cle, ale, ce_n, we_n, re_n, wp_n;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   nand_host #(.MAX_POLLS(20)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .io_out(io_out), .io_oe_out(io_oe_out), .io_in(io_in),
      .cmd_latch_out(cle), .addr_latch_out(ale), .chip_en_n_out(ce_n),
      .write_strobe_n_out(we_n), .read_strobe_n_out(re_n), .write_protect_n_out(wp_n));
   flash_model flash (.byte_in(io_out), .cle_in(cle), .ale_in(ale), .ce_n_in(ce_n),
      .we_n_in(we_n), .re_n_in(re_n), .wp_n_in(wp_n), .fail_d1_in(fail_d1),
      .resp_out(io_in));
   ////////////////////////////////////////////////////////////////////////////////
   // register port and comparison helpers
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   // blocks 0 and 1 share page 3 in the lower half; a poke is a reset order written while busy and ignored
   task automatic run_op(input logic [2:0] op, input logic dual, input logic poke);
      logic [31:0] s;
      int n;
      flash.cmd_log.delete();
      flash.addr_count = 0;
      wr(REG_ROW_A, 32'h3);
      wr(REG_ROW_B, 32'h43);
      wr(REG_COL, 32'h0);
      wr(REG_CTRL, {27'h0, 1'b1, dual, op});
      if (poke) begin
         wr(REG_CTRL, {27'h0, 1'b1, 1'b0, OP_RESET});
      end
      for (n = 0; n < 2000; n++) begin
         rd(REG_STATUS, s);
         if (s[0] === 1'b0) begin
            break;
         end
         if (s[2] === 1'b1) begin
            wr(REG_DATA, 32'h1a5);
         end
      end
      chk("order done", {31'h0, n < 2000}, 32'h1);
      chk("protect idle", {31'h0, wp_n}, {31'h0, op == OP_PROG_CACHE || op == OP_COPY_CACHE});
   endtask
   task automatic chk_log(input logic [7:0] e [$], input int addrs, input logic [7:0] st);
      logic [31:0] s;
      foreach (e[i]) begin
         chk("command", i < flash.cmd_log.size() ? {24'h0, flash.cmd_log[i]} : 32'hx,
             {24'h0, e[i]});
      end
      chk("address bytes", flash.addr_count, addrs);
      rd(REG_FLASH_ST, s);
      chk("flash status", s, {24'h0, st});
      rd(REG_STATUS, s);
      chk("error flag", {31'h0, s[3]}, {31'h0, st[0]});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_erase;
      run_op(OP_ERASE, 1'b0, 1'b1);
      chk_log('{8'h60, 8'hd0, 8'h71}, 3, 8'he0);
   endtask
   task automatic t_dual_prog_fail;
      fail_d1 <= 1'b1;
      run_op(OP_PROG_FINAL, 1'b1, 1'b0);
      chk_log('{8'h80, 8'h11, 8'h81, 8'h10, 8'h71}, 10, 8'he5);
      fail_d1 <= 1'b0;
   endtask
   task automatic t_cache_prog;
      run_op(OP_PROG_CACHE, 1'b0, 1'b0);
      chk_log('{8'h80, 8'h15, 8'h71}, 5, 8'hf0);
   endtask
   task automatic t_dual_erase;
      run_op(OP_ERASE, 1'b1, 1'b0);
      chk_log('{8'h60, 8'h60, 8'hd0, 8'h71}, 6, 8'he0);
   endtask
   task automatic t_copy;
      run_op(OP_COPY_CACHE, 1'b0, 1'b0);
      chk_log('{8'h8c, 8'h15, 8'h71}, 5, 8'he0);
      run_op(OP_COPY_FINAL, 1'b0, 1'b0);
      chk_log('{8'h8c, 8'h10, 8'h71}, 5, 8'he0);
   endtask
   // two rows of block 0 on different pages never reach the port
   task automatic t_pair_refused;
      logic [31:0] s;
      flash.cmd_log.delete();
      wr(REG_ROW_B, 32'h5);
      wr(REG_CTRL, {27'h0, 1'b1, 1'b1, OP_PROG_FINAL});
      rd(REG_STATUS, s);
      chk("refused pair status", s, 32'h8);
      chk("refused pair port", flash.cmd_log.size(), 0);
   endtask
   task automatic t_reset_unmapped;
      logic [31:0] s;
      run_op(OP_RESET, 1'b0, 1'b0);
      chk("reset command", {24'h0, flash.cmd_log[0]}, 32'hff);
      wr(4'hf, 32'h10);
      rd(REG_STATUS, s);
      chk("unmapped write idle", {31'h0, s[0]}, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard and main sequence
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_erase();
      t_dual_prog_fail();
      t_cache_prog();
      t_dual_erase();
      t_copy();
      t_pair_refused();
      t_reset_unmapped();
      tally_and_finish();
   end
endmodule // nand_cache_program_copy_erase_test
